/* logic/atxcfg_pkg.sv */
/*
 * constants and carrier types for the transmitter configuration register bank.
 * assumes one 50 MHz clock shared with the serial interface that issues accesses.
 */
package atxcfg_pkg;
    localparam int CLOCK_HZ = 50_000_000;
    // register indices
    localparam logic [7:0] ADDR_IDENT = 8'h00;
    localparam logic [7:0] ADDR_CFG_A = 8'h01;
    localparam logic [7:0] ADDR_CFG_B = 8'h02;
    localparam logic [7:0] ADDR_EMU = 8'h03;
    localparam logic [7:0] ADDR_STSEL = 8'h04;
    localparam logic [7:0] ADDR_SPACE_HI = 8'h0d;
    localparam logic [7:0] ADDR_SPACE_LO = 8'h0e;
    localparam logic [7:0] ADDR_APPLY = 8'h0f;
    localparam logic [7:0] ADDR_TXEN = 8'h10;
    localparam logic [7:0] ADDR_DATA = 8'h11;
    localparam logic [7:0] ADDR_STATUS = 8'h12;
    // writable masks; blank positions read zero
    localparam logic [7:0] MASK_CFG_A = 8'h7f;
    localparam logic [7:0] MASK_STSEL = 8'h07;
    localparam logic [7:0] MASK_BIT0 = 8'h01;
    localparam logic [7:0] RESET_VALUE = 8'h00;
    // field positions
    localparam int POS_MODE = 0;
    localparam int POS_CLKOUT = 1;
    localparam int POS_CLKSBY = 2;
    localparam int POS_ANSHP = 3;
    localparam int POS_PLLBW = 5;
    localparam int POS_BOOST = 6;
    localparam int POS_CAP = 0;
    localparam int POS_CKDIV = 5;
    localparam int POS_FRQ = 0;
    localparam int POS_HDEV = 3;
    localparam int POS_PWR = 4;
    localparam int POS_FXMODE = 6;
    localparam int POS_FIXED = 7;
    localparam int POS_FRAC_TOP = 11;
    localparam int POS_INT = 12;
    localparam logic [2:0] SRC_CLOCK = 3'h2;
    localparam logic [4:0] INT_OFFSET = 5'h10;
    // analog figures
    localparam logic [9:0] BW_LOW_KHZ = 10'd300;
    localparam logic [9:0] BW_HIGH_KHZ = 10'd600;
    localparam logic [11:0] RISE_SLOW_NS = 12'd3000;
    localparam logic [11:0] RISE_FAST_NS = 12'd1500;
    localparam logic [6:0] DEV_HIGH_KHZ = 7'd100;
    localparam logic [6:0] DEV_LOW_KHZ = 7'd32;
    localparam logic [3:0] BACKOFF_1_DB = 4'd3;
    localparam logic [3:0] BACKOFF_2_DB = 4'd6;
    localparam logic [3:0] BACKOFF_3_DB = 4'd10;
    // divide ratios for a 16 MHz crystal, in units of 1e-5
    localparam logic [21:0] RATIO_1 = 22'd1968750;
    localparam logic [21:0] RATIO_2 = 22'd2710125;
    localparam logic [21:0] RATIO_3 = 22'd2437500;
    localparam logic [21:0] RATIO_4 = 22'd2612500;
    localparam logic [21:0] RATIO_5 = 22'd2325000;
    localparam logic [21:0] RATIO_6 = 22'd2156250;
    localparam logic [21:0] RATIO_7 = 22'd2712000;

    typedef struct packed {
        logic wr;
        logic rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } atx_access_type;

    typedef struct packed {
        logic active;
        logic fsk;
        logic [3:0] backoff_db;
        logic [6:0] deviation_khz;
        logic ratio_valid;
        logic [21:0] ratio;
    } atx_emulation_type;

    typedef struct packed {
        logic [4:0] integer_part;
        logic [11:0] fraction;
    } atx_divider_type;
endpackage

/* logic/atxcfg_regs.sv */
/*
 * configuration register bank of the ask/fsk transmitter with its decoded controls.
 * assumes the serial front end delivers one-cycle access strobes on the same clock,
 * and that status buses, standby state and pin selection come from logic on that clock.
 */
// Behaviour
// - cfg_a bit 6 picks normal or extended drive on general output one.
// - pll bandwidth bit gives 300 kHz when clear, 600 kHz when set.
// - shaping code: open with extension, 3.0us, 1.5us, or off without extension.
// - standby clock bit keeps the crystal clock output running in standby.
// - clock output bit drives the clock on output one when source select is 2, outside standby or with the standby clock bit set.
// - clock divider code 000,001,010,011,1xx divides by 1,2,4,8,16.
// - emulation bit 7 enables emulation; bit 6 then selects fsk or ask.
// - emulation power code backs off 0, 3, 6 or 10 dB below maximum.
// - emulation deviation bit gives 100 kHz when set, 32 kHz when clear.
// - emulation frequency code decodes as manual mode; code 000 is invalid.
// - codes 001 to 111 map to the seven fixed divide ratios for 16 MHz.
// - low three bits of status select choose the status bus read back.
// - identification register is read-only and always returns a fixed code.
// - cfg_a bit 0 selects ask when clear and fsk when set.
// - five-bit capacitor field picks one of 32 levels, independent of all else.
// - divider word: top 4 bits integer plus 16, low 12 bits fraction.
// - writing 1 to hop applies dividers; hardware clears it once applied.
module atxcfg_regs
    import atxcfg_pkg::*;
#(
    parameter logic [7:0] IDENT_CODE = 8'h5c // arbitrary value
) (
    input wire logic clock,
    input wire logic nrst,
    input wire atx_access_type access,
    input wire logic [63:0] status_buses,
    input wire logic standby_state,
    input wire logic [2:0] output1_source_select,
    output logic [7:0] read_data,
    output logic output1_drive_boost,
    output logic [9:0] pll_bandwidth_khz,
    output logic shaping_resistor_node_open,
    output logic pulse_extension_on,
    output logic [11:0] shaping_rise_ns,
    output logic crystal_clock_run,
    output logic clock_on_general_output_one,
    output logic [4:0] clock_divide_ratio,
    output logic fsk_mode,
    output logic [4:0] pa_cap_code,
    output atx_emulation_type emulation,
    output atx_divider_type space_divider,
    output logic divider_applied,
    output logic transmit_enable,
    output logic modulation_data
);
    logic [7:0] radio_config_a;
    logic [7:0] radio_config_b;
    logic [7:0] emulation_config;
    logic [7:0] status_bus_select;
    logic [7:0] space_divider_upper;
    logic [7:0] space_divider_lower;
    logic hop_pending;
    logic tx_enable_bit;
    logic data_bit;
    logic [7:0] next_read_data;
    logic [7:0] selected_status;
    logic [15:0] space_word;

    function automatic logic write_to(input atx_access_type a, input logic [7:0] at);
        write_to = a.wr && (a.addr == at);
    endfunction

    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            radio_config_a <= RESET_VALUE;
            radio_config_b <= RESET_VALUE;
            emulation_config <= RESET_VALUE;
            status_bus_select <= RESET_VALUE;
        end else begin
            if (write_to(access, ADDR_CFG_A)) begin
                radio_config_a <= access.wdata & MASK_CFG_A;
            end
            if (write_to(access, ADDR_CFG_B)) begin
                radio_config_b <= access.wdata;
            end
            if (write_to(access, ADDR_EMU)) begin
                emulation_config <= access.wdata;
            end
            if (write_to(access, ADDR_STSEL)) begin
                status_bus_select <= access.wdata & MASK_STSEL;
            end
        end
    end

    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            space_divider_upper <= RESET_VALUE;
            space_divider_lower <= RESET_VALUE;
            tx_enable_bit <= 1'b0;
            data_bit <= 1'b0;
        end else begin
            if (write_to(access, ADDR_SPACE_HI)) begin
                space_divider_upper <= access.wdata;
            end
            if (write_to(access, ADDR_SPACE_LO)) begin
                space_divider_lower <= access.wdata;
            end
            if (write_to(access, ADDR_TXEN)) begin
                tx_enable_bit <= access.wdata[0];
            end
            if (write_to(access, ADDR_DATA)) begin
                data_bit <= access.wdata[0];
            end
        end
    end

    // hop: the load completes one cycle after the bit is seen, then self-clears;
    // a fresh write of 1 in the clearing cycle wins so no request is lost
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            hop_pending <= 1'b0;
        end else if (write_to(access, ADDR_APPLY)) begin
            hop_pending <= access.wdata[0];
        end else if (hop_pending) begin
            hop_pending <= 1'b0;
        end
    end

    assign space_word = {space_divider_upper, space_divider_lower};

    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            space_divider <= '0;
            divider_applied <= 1'b0;
        end else begin
            divider_applied <= hop_pending;
            if (hop_pending) begin
                space_divider.integer_part <= {1'b0, space_word[15:POS_INT]} + INT_OFFSET;
                space_divider.fraction <= space_word[POS_FRAC_TOP:0];
            end
        end
    end

    assign selected_status = status_buses[status_bus_select[2:0] * 8 +: 8];

    always_comb begin
        unique case (access.addr)
            ADDR_IDENT: next_read_data = IDENT_CODE;
            ADDR_CFG_A: next_read_data = radio_config_a;
            ADDR_CFG_B: next_read_data = radio_config_b;
            ADDR_EMU: next_read_data = emulation_config;
            ADDR_STSEL: next_read_data = status_bus_select;
            ADDR_SPACE_HI: next_read_data = space_divider_upper;
            ADDR_SPACE_LO: next_read_data = space_divider_lower;
            ADDR_APPLY: next_read_data = {7'h00, hop_pending} & MASK_BIT0;
            ADDR_TXEN: next_read_data = {7'h00, tx_enable_bit};
            ADDR_DATA: next_read_data = {7'h00, data_bit};
            ADDR_STATUS: next_read_data = selected_status;
            default: next_read_data = 8'h00;
        endcase
    end

    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            read_data <= 8'h00;
        end else if (access.rd) begin
            read_data <= next_read_data;
        end
    end

    // front-end controls from the radio configuration and the transmit enable and data bits
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            output1_drive_boost <= 1'b0;
            pll_bandwidth_khz <= BW_LOW_KHZ;
            fsk_mode <= 1'b0;
            pa_cap_code <= 5'h00;
            transmit_enable <= 1'b0;
            modulation_data <= 1'b0;
        end else begin
            output1_drive_boost <= radio_config_a[POS_BOOST];
            // bandwidth choice is left to the host, see the fractional-n advice
            pll_bandwidth_khz <= radio_config_a[POS_PLLBW] ? BW_HIGH_KHZ : BW_LOW_KHZ;
            fsk_mode <= radio_config_a[POS_MODE];
            pa_cap_code <= radio_config_b[POS_CAP +: 5];
            transmit_enable <= tx_enable_bit;
            modulation_data <= data_bit;
        end
    end

    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            shaping_resistor_node_open <= 1'b1;
            pulse_extension_on <= 1'b1;
            shaping_rise_ns <= 12'h000;
        end else begin
            unique case (radio_config_a[POS_ANSHP +: 2])
                2'b00: begin
                    shaping_resistor_node_open <= 1'b1;
                    pulse_extension_on <= 1'b1;
                    shaping_rise_ns <= 12'h000;
                end
                2'b01: begin
                    shaping_resistor_node_open <= 1'b0;
                    pulse_extension_on <= 1'b1;
                    shaping_rise_ns <= RISE_SLOW_NS;
                end
                2'b10: begin
                    shaping_resistor_node_open <= 1'b0;
                    pulse_extension_on <= 1'b1;
                    shaping_rise_ns <= RISE_FAST_NS;
                end
                2'b11: begin
                    shaping_resistor_node_open <= 1'b0;
                    pulse_extension_on <= 1'b0;
                    shaping_rise_ns <= 12'h000;
                end
            endcase
        end
    end

    // crystal clock output; in standby only the standby enable keeps it alive
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            crystal_clock_run <= 1'b0;
            clock_on_general_output_one <= 1'b0;
            clock_divide_ratio <= 5'd1;
        end else begin
            crystal_clock_run <= standby_state ? radio_config_a[POS_CLKSBY] : 1'b1;
            clock_on_general_output_one <= radio_config_a[POS_CLKOUT]
                && (output1_source_select == SRC_CLOCK)
                && (!standby_state || radio_config_a[POS_CLKSBY]);
            if (radio_config_b[POS_CKDIV + 2]) begin
                clock_divide_ratio <= 5'd16;
            end else begin
                clock_divide_ratio <= 5'd1 << radio_config_b[POS_CKDIV +: 2];
            end
        end
    end

    // emulation decode
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            emulation <= '0;
        end else begin
            emulation.active <= emulation_config[POS_FIXED];
            emulation.fsk <= emulation_config[POS_FIXED] && emulation_config[POS_FXMODE];
            emulation.deviation_khz <= emulation_config[POS_HDEV] ? DEV_HIGH_KHZ
                                                                   : DEV_LOW_KHZ;
            unique case (emulation_config[POS_PWR +: 2])
                2'b00: emulation.backoff_db <= 4'd0;
                2'b01: emulation.backoff_db <= BACKOFF_1_DB;
                2'b10: emulation.backoff_db <= BACKOFF_2_DB;
                2'b11: emulation.backoff_db <= BACKOFF_3_DB;
            endcase
            emulation.ratio_valid <= emulation_config[POS_FRQ +: 3] != 3'b000;
            unique case (emulation_config[POS_FRQ +: 3])
                3'b000: emulation.ratio <= 22'd0;
                3'b001: emulation.ratio <= RATIO_1;
                3'b010: emulation.ratio <= RATIO_2;
                3'b011: emulation.ratio <= RATIO_3;
                3'b100: emulation.ratio <= RATIO_4;
                3'b101: emulation.ratio <= RATIO_5;
                3'b110: emulation.ratio <= RATIO_6;
                3'b111: emulation.ratio <= RATIO_7;
            endcase
        end
    end
endmodule

/* tb/atxcfg_host.sv */
/* host model: issues one-cycle register strobes and collects read data.
   assumes the shared clock and that calls begin after reset release. */
module atxcfg_host
    import atxcfg_pkg::*;
(
    input wire logic clock,
    input wire logic [7:0] read_data,
    output atx_access_type access
);
    timeunit 1ns;
    timeprecision 1ns;
    initial access = '0;
    // bandwidth choice is left to the stimulus: the host only writes what it is given
    task automatic xfer(input logic w, input logic [7:0] ad, input logic [7:0] d,
                        output logic [7:0] q);
        @(posedge clock);
        access <= '{wr: w, rd: !w, addr: ad, wdata: d};
        @(posedge clock);
        access <= '0;
        #1 q = read_data;
    endtask
endmodule

/* tb/atxcfg_regs_props.sv */
/* checker: decoded controls and read data against the accesses that cause them.
   assumes it is bound to the register bank and sees only its ports. */
module atxcfg_regs_props
    import atxcfg_pkg::*;
#(
    parameter logic [7:0] IDENT_CODE = 8'h5c
) (
    input wire logic clock,
    input wire logic nrst,
    input wire atx_access_type access,
    input wire logic standby_state,
    input wire logic [7:0] read_data,
    input wire logic output1_drive_boost,
    input wire logic [9:0] pll_bandwidth_khz,
    input wire logic crystal_clock_run,
    input wire logic [4:0] clock_divide_ratio,
    input wire logic fsk_mode,
    input wire logic [4:0] pa_cap_code,
    input wire atx_emulation_type emulation,
    input wire logic divider_applied
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking @(posedge clock); endclocking
    default disable iff (!nrst);
    sequence s_wr(logic [7:0] ad);
        access.wr && access.addr == ad;
    endsequence
    sequence s_hop;
        s_wr(ADDR_APPLY) ##0 access.wdata[0];
    endsequence
    property p_boost;
        s_wr(ADDR_CFG_A) |-> ##2 output1_drive_boost == $past(access.wdata[POS_BOOST], 2);
    endproperty
    a_boost: assert property (p_boost) else $error("boost wrong");
    property p_bw;
        s_wr(ADDR_CFG_A) |-> ##2
            pll_bandwidth_khz == ($past(access.wdata[POS_PLLBW], 2) ? BW_HIGH_KHZ : BW_LOW_KHZ);
    endproperty
    a_bw: assert property (p_bw) else $error("bandwidth wrong");
    property p_mode;
        s_wr(ADDR_CFG_A) |-> ##2 fsk_mode == $past(access.wdata[POS_MODE], 2);
    endproperty
    a_mode: assert property (p_mode) else $error("mode wrong");
    property p_cap;
        s_wr(ADDR_CFG_B) |-> ##2 pa_cap_code == $past(access.wdata[4:0], 2);
    endproperty
    a_cap: assert property (p_cap) else $error("cap wrong");
    property p_div;
        s_wr(ADDR_CFG_B) |-> ##2 clock_divide_ratio ==
            ($past(access.wdata[7], 2) ? 5'd16 : 5'd1 << $past(access.wdata[6:5], 2));
    endproperty
    a_div: assert property (p_div) else $error("divider wrong");
    property p_emu;
        s_wr(ADDR_EMU) |-> ##2 emulation.active == $past(access.wdata[POS_FIXED], 2) &&
            emulation.fsk == ($past(access.wdata[POS_FIXED], 2) && $past(access.wdata[6], 2));
    endproperty
    a_emu: assert property (p_emu) else $error("emulation wrong");
    property p_ident;
        access.rd && access.addr == ADDR_IDENT |=> read_data == IDENT_CODE;
    endproperty
    a_ident: assert property (p_ident) else $error("ident wrong");
    property p_hop;
        s_hop |-> ##2 divider_applied ##1 !divider_applied;
    endproperty
    a_hop: assert property (p_hop) else $error("hop pulse wrong");
    property p_run;
        // sampled nrst keeps the release edge out: the flop still sees reset there
        nrst && !standby_state |=> crystal_clock_run;
    endproperty
    a_run: assert property (p_run) else $error("clock run wrong");
endmodule
bind atxcfg_regs atxcfg_regs_props #(.IDENT_CODE(IDENT_CODE)) u_atxcfg_regs_props (
    .clock(clock), .nrst(nrst), .access(access), .standby_state(standby_state),
    .read_data(read_data), .output1_drive_boost(output1_drive_boost),
    .pll_bandwidth_khz(pll_bandwidth_khz), .crystal_clock_run(crystal_clock_run),
    .clock_divide_ratio(clock_divide_ratio), .fsk_mode(fsk_mode), .pa_cap_code(pa_cap_code),
    .emulation(emulation), .divider_applied(divider_applied));

/* tb/atxcfg_regs_tb_top.sv */
/* bench: a masked register model predicts reads and decoded controls.
   assumes the host model and checker are compiled alongside. */
module atxcfg_regs_tb_top
    import atxcfg_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    localparam logic [7:0] IDENT = 8'h3b; // arbitrary value
    logic clock = 1'b0, nrst = 1'b0, standby_state = 1'b0;
    logic [2:0] src = 3'h0;
    logic [63:0] status_buses = '0;
    atx_access_type access;
    logic [7:0] read_data, q, mdl [0:31];
    logic [9:0] bw;
    logic [4:0] cap, ckr;
    logic [11:0] rise;
    logic boost, open_n, ext_on, run, clk_out, fsk, txen, mdata, applied;
    atx_emulation_type emu;
    atx_divider_type sdiv;
    integer seed = 32'h2142, mismatches = 0, samples_checked = 0, cycles = 0;
    logic [31:0] rnd;
    int pw [4] = '{0, 3, 6, 10};
    logic [21:0] rt [8] = '{0, RATIO_1, RATIO_2, RATIO_3, RATIO_4, RATIO_5, RATIO_6, RATIO_7};
    atxcfg_regs #(.IDENT_CODE(IDENT)) u_atxcfg_regs (
        .clock(clock), .nrst(nrst), .access(access), .status_buses(status_buses),
        .standby_state(standby_state), .output1_source_select(src), .read_data(read_data),
        .output1_drive_boost(boost), .pll_bandwidth_khz(bw),
        .shaping_resistor_node_open(open_n), .pulse_extension_on(ext_on), .shaping_rise_ns(rise),
        .crystal_clock_run(run), .clock_on_general_output_one(clk_out),
        .clock_divide_ratio(ckr), .fsk_mode(fsk), .pa_cap_code(cap), .emulation(emu),
        .space_divider(sdiv), .divider_applied(applied), .transmit_enable(txen),
        .modulation_data(mdata));
    atxcfg_host u_atxcfg_host (.clock(clock), .read_data(read_data), .access(access));
    always #10 clock = ~clock;
    always @(posedge clock) begin
        cycles = cycles + 1;
        if (cycles == 10000) begin
            $display("Error %0t timeout", $time);
            mismatches = mismatches + 1;
            test_done();
        end
    end
    task automatic test_done();
        $display("compared %0d mismatched %0d", samples_checked, mismatches);
        if (mismatches == 0 && samples_checked > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    task automatic cmp(input logic [31:0] got, input logic [31:0] exp, input string what);
        samples_checked = samples_checked + 1;
        if (got !== exp) begin
            mismatches = mismatches + 1;
            $display("Error %0t %s got %0h want %0h", $time, what, got, exp);
        end
    endtask
    // blank positions and read-only places keep nothing of a write
    function automatic logic [7:0] wmask(input logic [7:0] ad);
        case (ad)
            ADDR_CFG_A: return MASK_CFG_A;
            ADDR_CFG_B, ADDR_EMU, ADDR_SPACE_HI, ADDR_SPACE_LO: return 8'hff;
            ADDR_STSEL: return MASK_STSEL;
            ADDR_TXEN, ADDR_DATA: return MASK_BIT0;
            default: return 8'h00;
        endcase
    endfunction
    function automatic logic [7:0] exp_rd(input logic [7:0] ad);
        if (ad == ADDR_IDENT) return IDENT;
        if (ad == ADDR_STATUS) return status_buses[8 * mdl[4][2:0] +: 8];
        return mdl[ad[4:0]];
    endfunction
    task automatic wr(input logic [7:0] ad, input logic [7:0] d);
        u_atxcfg_host.xfer(1'b1, ad, d, q);
        mdl[ad[4:0]] = d & wmask(ad);
    endtask
    task automatic cmp_rd(input logic [7:0] ad);
        u_atxcfg_host.xfer(1'b0, ad, 8'h00, q);
        cmp(q, exp_rd(ad), "read");
    endtask
    task automatic chk_dec();
        logic [7:0] a, b, e;
        a = mdl[1];
        b = mdl[2];
        e = mdl[3];
        cmp({boost, fsk}, {a[6], a[0]}, "boost mode");
        cmp(bw, a[5] ? 600 : 300, "bandwidth");
        cmp({open_n, ext_on}, {a[4:3] == 2'b00, a[4:3] != 2'b11}, "shaping");
        cmp(rise, (a[4] ^ a[3]) ? (a[3] ? 3000 : 1500) : 0, "rise");
        // logical operators: a bitwise invert would be widened to 32 bits here
        cmp(run, !standby_state || a[2], "clock run");
        cmp(clk_out, a[1] && src == 3'h2 && (!standby_state || a[2]), "clock pin");
        cmp(ckr, b[7] ? 16 : 1 << b[6:5], "clock divide");
        cmp(cap, b[4:0], "cap");
        cmp({emu.active, emu.fsk}, {e[7], e[7] & e[6]}, "emulation");
        cmp(emu.backoff_db, pw[e[5:4]], "backoff");
        cmp(emu.deviation_khz, e[3] ? 100 : 32, "deviation");
        cmp({emu.ratio_valid, emu.ratio}, {e[2:0] != 0, rt[e[2:0]]}, "ratio");
    endtask
    initial begin
        for (int i = 0; i < 32; i++) mdl[i] = 8'h00;
        status_buses = {$random(seed), $random(seed)};
        repeat (8) @(posedge clock);
        nrst <= 1'b1;
        for (int i = 0; i < 32; i++) cmp_rd(i[7:0]);
        $display("reset read test done");
        for (int i = 0; i < 32; i++) wr(i[7:0], $random(seed));
        for (int i = 0; i < 32; i++) cmp_rd(i[7:0]);
        cmp({txen, mdata}, {mdl[16][0], mdl[17][0]}, "enable data");
        for (int i = 0; i < 8; i++) begin
            wr(ADDR_STSEL, {5'h1f, i[2:0]});
            cmp_rd(ADDR_STSEL);
            cmp_rd(ADDR_STATUS);
        end
        $display("write read and status test done");
        for (int i = 0; i < 256; i++) begin
            rnd = $random(seed);
            @(posedge clock);
            standby_state <= rnd[0];
            src <= rnd[3:1];
            wr(ADDR_CFG_A, rnd[11:4]);
            wr(ADDR_CFG_B, i[7:0]);
            wr(ADDR_EMU, i[7:0] ^ 8'h5a);
            @(posedge clock);
            #1 chk_dec();
        end
        $display("decode test done");
        rnd = $random(seed);
        wr(ADDR_SPACE_HI, rnd[15:8]);
        wr(ADDR_SPACE_LO, rnd[7:0]);
        wr(ADDR_APPLY, 8'h01);
        @(posedge clock);
        #1 cmp(sdiv, {5'h10 + rnd[15:12], rnd[11:0]}, "divider word");
        cmp(applied, 1'b1, "applied pulse");
        cmp_rd(ADDR_APPLY);
        cmp(applied, 1'b0, "applied end");
        $display("hop test done");
        test_done();
    end
endmodule
